// [design/pihs_input_sequencer.v]
// Input handshake sequencer of a wide parallel peripheral port with an APB register slave.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
// Function
// RQ1: Reset drives output direction, data lines zero.
// RQ2: Power line never sampled by input sequence.
// RQ3: Asserted stop aborts the input operation.
// RQ4: Input branch turns data lines to input.
// RQ5: Step pulse, then stop test, then busy.
// RQ6: Busy asserted: re-step, retest stop and busy.
// RQ7: Wait for strobe acknowledge without timeout.
// RQ8: Peripheral data valid 250 ns after acknowledge.
// RQ9: Peripheral holds data, acknowledge until strobe.
// RQ10: Hold function strobe until acknowledge drops.
// RQ11: Peripheral busy only after function strobe.
// RQ12: Drop function strobe to finish exchange.
// RQ13: Loop to step while words remain, else end.
// RQ14: Peripheral asserts stop to end early.
// RQ15: End line asserted during end-of-block service.
// RQ16: Data/command and spare stay outside sequences.
// RQ17: Mode-set base 400h, size codes 1..3; the code also takes size code 0 (8-bit words, the reset value).
// RQ18: Branch base 200h, plus 30h out, 48h in.
// RQ19: All service vectors share one six-word group.
// RQ20: Count is negative bytes, buffer address minus one.
// RQ21: Unwaited sequencer steps spaced at least 250 ns.
// RQ22: Step pulse one interval, re-trigger same width.
`include "pihs_regs.vh"

module pihs_input_sequencer #(
	parameter DATA_W = 32,
	parameter VECTOR_BASE = 16'h00c0
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [DATA_W-1:0] data_in,
	output reg [DATA_W-1:0] data_out,
	output reg data_oe_n,
	output reg step_pulse,
	output reg func_strobe,
	output reg end_line,
	output reg data_command,
	input wire strobe_ack,
	input wire busy_line,
	input wire stop_line,
	input wire power_line,
	input wire spare_line,
	output reg [15:0] data_vector_address,
	output reg data_service,
	output reg eob_service
);

	// ==========================================================================
	// Sequencer states.
	localparam [3:0] ST_OUT = 4'h0;
	localparam [3:0] ST_TURN = 4'h1;
	localparam [3:0] ST_STEP = 4'h2;
	localparam [3:0] ST_STOP = 4'h3;
	localparam [3:0] ST_BUSY = 4'h4;
	localparam [3:0] ST_WACK = 4'h5;
	localparam [3:0] ST_FSTB = 4'h6;
	localparam [3:0] ST_DROP = 4'h7;
	localparam [3:0] ST_TERM = 4'h8;
	localparam [7:0] STEP_CYC = `PIHS_STEP_CYC;

	reg [3:0] state_r;
	reg [7:0] div_r;
	reg tick_r;
	reg [1:0] size_r;
	reg input_r;
	reg done_r;
	reg abort_r;
	reg [31:0] count_r;
	reg [DATA_W-1:0] rdata_r;
	wire wr_en;
	wire rd_en;
	wire cmd_wr;
	wire [15:0] cmd;
	wire [31:0] count_sum;
	reg [31:0] status_w;
	reg [31:0] rd_mux;
	reg rd_ok;

	// ==========================================================================
	// Number of bytes in one word for a size code.
	function [31:0] pihs_bytes;
		input [1:0] size;
		begin
			pihs_bytes = {30'h0, size} + 32'h1;
		end
	endfunction

	// Mask that keeps the bytes of one word of the given size.
	function [DATA_W-1:0] pihs_mask;
		input [1:0] size;
		reg [31:0] m;
		begin
			case (size)
				`PIHS_SIZE_8: m = 32'h0000_00ff;
				`PIHS_SIZE_16: m = 32'h0000_ffff;
				`PIHS_SIZE_24: m = 32'h00ff_ffff;
				default: m = 32'hffff_ffff;
			endcase
			pihs_mask = m[DATA_W-1:0];
		end
	endfunction

	// ==========================================================================
	// APB decode: one wait state, writes act at the completing edge.
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_en = psel & penable & ~pready;
	assign cmd_wr = wr_en & (paddr == `PIHS_OFF_CMD);
	assign cmd = pwdata[15:0];
	assign count_sum = count_r + pihs_bytes(size_r);

	always @* begin
		status_w = 32'h0;
		status_w[3:0] = state_r;
		status_w[`PIHS_ST_ACTIVE] = (state_r != ST_OUT) && (state_r != ST_TERM);
		status_w[`PIHS_ST_DONE] = done_r;
		status_w[`PIHS_ST_ABORT] = abort_r;
		status_w[`PIHS_ST_SPARE] = spare_line;
		status_w[`PIHS_ST_STOP] = stop_line;
		status_w[`PIHS_ST_BUSY] = busy_line;
		status_w[`PIHS_ST_ACK] = strobe_ack;
		status_w[`PIHS_ST_INPUT] = input_r;
		status_w[13:12] = size_r;
		status_w[`PIHS_ST_RQS] = data_command;
	end

	always @* begin
		rd_mux = 32'h0;
		rd_ok = 1'b1;
		case (paddr)
			`PIHS_OFF_CMD: rd_mux = 32'h0;
			`PIHS_OFF_STATUS: rd_mux = status_w;
			`PIHS_OFF_DATA: rd_mux[DATA_W-1:0] = rdata_r;
			`PIHS_OFF_COUNT: rd_mux = count_r;
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= rd_en;
			if (rd_en) begin
				prdata <= pwrite ? 32'h0 : rd_mux;
				pslverr <= ~rd_ok;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Step divider: one tick per sequencer step interval.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 8'h0;
			tick_r <= 1'b0;
		end else if (div_r == STEP_CYC - 8'h1) begin
			div_r <= 8'h0;
			tick_r <= 1'b1; // see RQ21
		end else begin
			div_r <= div_r + 8'h1;
			tick_r <= 1'b0;
		end
	end

	// ==========================================================================
	// Command handling and the input sequence.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_OUT;
			size_r <= `PIHS_SIZE_8;
			input_r <= 1'b0;
			done_r <= 1'b0;
			abort_r <= 1'b0;
			count_r <= 32'h0;
			rdata_r <= {DATA_W{1'b0}};
			data_out <= {DATA_W{1'b0}};
			data_oe_n <= 1'b0;
			step_pulse <= 1'b0;
			func_strobe <= 1'b0;
			end_line <= 1'b0;
			data_command <= 1'b0;
			data_vector_address <= 16'h0;
			data_service <= 1'b0;
			eob_service <= 1'b0;
		end else begin
			data_service <= 1'b0;
			eob_service <= 1'b0;
			if (wr_en && paddr == `PIHS_OFF_COUNT) begin
				count_r <= pwdata; // see RQ20
			end
			if (cmd_wr && cmd[`PIHS_RESET_BIT] && !cmd[`PIHS_MODE_BIT] &&
				!cmd[`PIHS_BRANCH_BIT]) begin
				state_r <= ST_OUT; // see RQ1
				input_r <= 1'b0;
				data_out <= {DATA_W{1'b0}};
				data_oe_n <= 1'b0;
				step_pulse <= 1'b0;
				func_strobe <= 1'b0;
				end_line <= 1'b0;
				done_r <= 1'b0;
				abort_r <= 1'b0;
			end else if (cmd_wr && cmd[`PIHS_MODE_BIT]) begin
				size_r <= cmd[`PIHS_SIZE_MSB:`PIHS_SIZE_LSB]; // see RQ17
				data_command <= cmd[`PIHS_RQS_BIT]; // see RQ16
			end else if (cmd_wr && cmd[`PIHS_BRANCH_BIT] && cmd[7:0] == `PIHS_BR_INPUT) begin
				state_r <= ST_TURN; // see RQ18
				done_r <= 1'b0;
				abort_r <= 1'b0;
				end_line <= 1'b0;
			end else if (cmd_wr && cmd[`PIHS_BRANCH_BIT] && cmd[7:0] == `PIHS_BR_OUTPUT) begin
				state_r <= ST_OUT; // see RQ18
				input_r <= 1'b0;
				data_oe_n <= 1'b0;
				end_line <= 1'b0;
			end else if (tick_r) begin
				case (state_r)
					ST_OUT: begin
						state_r <= ST_OUT;
					end
					ST_TURN: begin
						input_r <= 1'b1;
						data_oe_n <= 1'b1; // see RQ4
						state_r <= ST_STEP;
					end
					ST_STEP: begin
						step_pulse <= 1'b1; // see RQ5
						state_r <= ST_STOP; // see RQ2
					end
					ST_STOP: begin
						step_pulse <= 1'b0; // see RQ22
						if (stop_line) begin
							abort_r <= 1'b1; // see RQ3
							end_line <= 1'b1;
							eob_service <= 1'b1;
							data_vector_address <= VECTOR_BASE + `PIHS_VEC_EOB;
							state_r <= ST_TERM;
						end else begin
							state_r <= ST_BUSY;
						end
					end
					ST_BUSY: begin
						state_r <= busy_line ? ST_STEP : ST_WACK; // see RQ6
					end
					ST_WACK: begin
						if (strobe_ack) begin
							state_r <= ST_FSTB; // see RQ7
						end
					end
					ST_FSTB: begin
						func_strobe <= 1'b1;
						rdata_r <= data_in & pihs_mask(size_r); // see RQ8
						count_r <= count_sum;
						data_service <= 1'b1;
						data_vector_address <= VECTOR_BASE + `PIHS_VEC_DATA; // see RQ19
						state_r <= ST_DROP;
					end
					ST_DROP: begin
						if (!strobe_ack) begin
							func_strobe <= 1'b0; // see RQ12
							if (count_r[31]) begin
								state_r <= ST_STEP; // see RQ13
							end else begin
								done_r <= 1'b1;
								end_line <= 1'b1; // see RQ15
								eob_service <= 1'b1;
								data_vector_address <= VECTOR_BASE + `PIHS_VEC_EOB;
								state_r <= ST_TERM;
							end
						end else begin
							func_strobe <= 1'b1; // see RQ10
						end
					end
					ST_TERM: begin
						state_r <= ST_TERM;
					end
					default: begin
						state_r <= ST_OUT;
					end
				endcase
			end
		end
	end

endmodule

// [design/pihs_regs.vh]
// Register offsets, command encodings, field positions and timing counts of the input sequencer.
`ifndef PIHS_REGS_VH
`define PIHS_REGS_VH
// ==========================================================================
// Register byte offsets
`define PIHS_OFF_CMD 12'h000
`define PIHS_OFF_STATUS 12'h004
`define PIHS_OFF_DATA 12'h008
`define PIHS_OFF_COUNT 12'h00c
// ==========================================================================
// Command words
`define PIHS_CMD_RESET 16'h0100
`define PIHS_CMD_MODE_BASE 16'h0400
`define PIHS_CMD_BRANCH_BASE 16'h0200
`define PIHS_BR_OUTPUT 8'h30
`define PIHS_BR_INPUT 8'h48
`define PIHS_MODE_BIT 10
`define PIHS_BRANCH_BIT 9
`define PIHS_RESET_BIT 8
`define PIHS_SIZE_LSB 0
`define PIHS_SIZE_MSB 1
`define PIHS_RQS_BIT 2
// ==========================================================================
// Word size field codes
`define PIHS_SIZE_8 2'h0
`define PIHS_SIZE_16 2'h1
`define PIHS_SIZE_24 2'h2
`define PIHS_SIZE_32 2'h3
// ==========================================================================
// Status bit positions
`define PIHS_ST_STATE_LSB 0
`define PIHS_ST_ACTIVE 4
`define PIHS_ST_DONE 5
`define PIHS_ST_ABORT 6
`define PIHS_ST_SPARE 7
`define PIHS_ST_STOP 8
`define PIHS_ST_BUSY 9
`define PIHS_ST_ACK 10
`define PIHS_ST_INPUT 11
`define PIHS_ST_SIZE_LSB 12
`define PIHS_ST_RQS 14
// ==========================================================================
// Vector offsets within the shared six-word group
`define PIHS_VEC_DATA 16'h0000
`define PIHS_VEC_EOB 16'h0004
// ==========================================================================
// Sequencer step timing
`define PIHS_CLK_NS 4
`define PIHS_STEP_NS 250
`define PIHS_STEP_CYC ((`PIHS_STEP_NS + `PIHS_CLK_NS - 1) / `PIHS_CLK_NS)
`endif

// [tb/pihs_seq_assertions.sv]
// Checker of the input sequencer handshake outputs.
`timescale 1ns/10ps
module pihs_seq_chk #(parameter DATA_W = 32) (
	input wire pclk,
	input wire presetn,
	input wire [DATA_W-1:0] data_out,
	input wire data_oe_n,
	input wire step_pulse,
	input wire func_strobe,
	input wire end_line,
	input wire strobe_ack,
	input wire eob_service
);
	reg [7:0] hi_r;
	// ==========================================================
	// Step width counter.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_r <= 8'h00;
		end else begin
			hi_r <= step_pulse ? hi_r + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_zero;
		!data_oe_n |-> data_out == 0;
	endproperty
	a_zero: assert property (p_zero) else $error("data not zero");
	property p_turn;
		step_pulse |-> data_oe_n;
	endproperty
	a_turn: assert property (p_turn) else $error("lines driven");
	property p_order;
		step_pulse |-> !func_strobe;
	endproperty
	a_order: assert property (p_order) else $error("step overlap");
	property p_ackwait;
		$rose(func_strobe) |-> $past(strobe_ack);
	endproperty
	a_ackwait: assert property (p_ackwait) else $error("strobe early");
	property p_hold;
		func_strobe && strobe_ack |=> func_strobe;
	endproperty
	a_hold: assert property (p_hold) else $error("strobe dropped");
	property p_drop;
		$fell(func_strobe) |-> !$past(strobe_ack);
	endproperty
	a_drop: assert property (p_drop) else $error("drop early");
	property p_end;
		eob_service |-> ##[0:1] end_line;
	endproperty
	a_end: assert property (p_end) else $error("no end");
	property p_width;
		$fell(step_pulse) |-> hi_r == 8'h3f;
	endproperty
	a_width: assert property (p_width) else $error("step width");
endmodule

// [tb/pihs_periph.sv]
// Peripheral model answering the input handshake.
`timescale 1ns/10ps
module pihs_periph (
	input wire pclk,
	input wire step_pulse,
	input wire func_strobe,
	input wire [3:0] busy_steps,
	input wire [3:0] stop_word,
	input wire [6:0] ack_dly,
	output logic [31:0] data_in,
	output logic strobe_ack,
	output logic busy_line,
	output wire stop_line
);
	logic fs_r = 1'b0, sp_r = 1'b0, armed_r = 1'b0;
	logic [3:0] word_r = 4'h0, left_r = 4'h0;
	logic [6:0] dly_r = 7'h00;
	assign stop_line = word_r == stop_word;
	initial begin
		data_in = 32'h0;
		strobe_ack = 1'b0;
		busy_line = 1'b0;
	end
	always @(posedge pclk) begin
		fs_r <= func_strobe;
		sp_r <= step_pulse;
		dly_r <= (armed_r && !busy_line && !strobe_ack) ? dly_r + 7'h01 : 7'h00;
		if (step_pulse && !sp_r) begin
			armed_r <= 1'b1;
		end
		if (armed_r && !busy_line && !strobe_ack && dly_r == ack_dly) begin
			strobe_ack <= 1'b1;
			data_in <= {16'hc3a5, 12'h000, word_r};
		end
		if (func_strobe && !fs_r) begin
			armed_r <= 1'b0;
			strobe_ack <= 1'b0;
			data_in <= ~data_in;
			word_r <= word_r + 4'h1;
			left_r <= busy_steps + 4'h1;
			busy_line <= busy_steps != 4'h0;
		end
		if (step_pulse && !sp_r && busy_line) begin
			left_r <= left_r - 4'h1;
			busy_line <= left_r != 4'h1;
		end
	end
endmodule

// [tb/pihs_input_sequencer_bench.sv]
// Self-checking bench of the input sequencer.
`timescale 1ns/10ps
`include "pihs_regs.vh"
module pihs_input_sequencer_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic power_line = 1'b0, spare_line = 1'b0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, q;
	logic [3:0] busy_steps = 4'h0, stop_word = 4'hf;
	logic [6:0] ack_dly = 7'h05;
	logic [15:0] vec_r;
	wire [31:0] prdata, data_in, data_out;
	wire [15:0] data_vector_address;
	wire pready, pslverr, data_oe_n, step_pulse, func_strobe, end_line, data_command;
	wire strobe_ack, busy_line, stop_line, data_service, eob_service;
	int fail_count = 0, cmp_count = 0, steps = 0, dsv = 0;
	pihs_input_sequencer pihs_input_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .data_in, .data_out, .data_oe_n,
		.step_pulse, .func_strobe, .end_line, .data_command, .strobe_ack, .busy_line,
		.stop_line, .power_line, .spare_line, .data_vector_address, .data_service,
		.eob_service);
	pihs_periph pihs_periph_inst (.pclk, .step_pulse, .func_strobe, .busy_steps, .stop_word,
		.ack_dly, .data_in, .strobe_ack, .busy_line, .stop_line);
	// ==========================================================
	// Clock, monitors and tasks.
	initial forever #2 pclk = ~pclk;
	always @(posedge step_pulse) steps++;
	always @(posedge pclk) begin
		if (data_service) dsv <= dsv + 1;
		if (eob_service) vec_r <= data_vector_address;
	end
	task wrap_up();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", nm, x, g);
			fail_count++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_end();
		int n;
		n = 0;
		while (end_line !== 1'b1 && n < 9000) begin
			@(posedge pclk);
			n++;
		end
		chk("end_line", 1, end_line);
	endtask
	initial begin
		#60000;
		fail_count++;
		wrap_up();
	end
	// ==========================================================
	// Test sequence.
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("oe_n", 0, data_oe_n);
		apb(1'b0, 12'h010, 0);
		chk("slverr", 1, e);
		for (int s = 1; s < 4; s++) begin
			apb(1'b1, `PIHS_OFF_CMD, `PIHS_CMD_MODE_BASE | s | 4);
			apb(1'b0, `PIHS_OFF_STATUS, 0);
			chk("size", s, q[13:12]);
		end
		chk("rqs", 1, data_command);
		spare_line <= 1'b1;
		power_line <= 1'b1;
		busy_steps <= 4'h1;
		apb(1'b1, `PIHS_OFF_COUNT, -8);
		apb(1'b1, `PIHS_OFF_CMD, `PIHS_CMD_BRANCH_BASE | `PIHS_BR_INPUT);
		wait_end();
		apb(1'b0, `PIHS_OFF_STATUS, 0);
		chk("done", 1, q[5]);
		chk("spare", 1, q[7]);
		apb(1'b0, `PIHS_OFF_DATA, 0);
		chk("data", 32'hc3a50001, q);
		chk("steps", 3, steps);
		chk("dsv", 2, dsv);
		chk("vec", 16'h00c4, vec_r);
		apb(1'b1, `PIHS_OFF_CMD, `PIHS_CMD_RESET);
		@(posedge pclk);
		chk("oe_n", 0, data_oe_n);
		apb(1'b1, `PIHS_OFF_CMD, `PIHS_CMD_MODE_BASE | 3);
		stop_word <= 4'h3;
		ack_dly <= 7'h7f;
		apb(1'b1, `PIHS_OFF_COUNT, -12);
		apb(1'b1, `PIHS_OFF_CMD, `PIHS_CMD_BRANCH_BASE | `PIHS_BR_INPUT);
		wait_end();
		apb(1'b0, `PIHS_OFF_STATUS, 0);
		chk("abort", 1, q[6]);
		apb(1'b0, `PIHS_OFF_DATA, 0);
		chk("data", 32'hc3a50002, q);
		apb(1'b1, `PIHS_OFF_CMD, `PIHS_CMD_BRANCH_BASE | `PIHS_BR_OUTPUT);
		apb(1'b0, `PIHS_OFF_STATUS, 0);
		chk("input_dir", 0, q[11]);
		chk("end_after_out", 0, end_line);
		chk("oe_n_out", 0, data_oe_n);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PIHS_OFF_STATUS, 0);
		chk("abort_rst", 0, q[6]);
		chk("oe_n_rst", 0, data_oe_n);
		wrap_up();
	end
endmodule
bind pihs_input_sequencer pihs_seq_chk #(.DATA_W(DATA_W)) pihs_seq_chk_inst (.pclk, .presetn,
	.data_out, .data_oe_n, .step_pulse, .func_strobe, .end_line, .strobe_ack, .eob_service);
